// >>> hw/i2cst_params.svh
/*
 * Constants of the I2C slave transmitter: status codes, general call address and bit count.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef I2CST_PARAMS_SVH
`define I2CST_PARAMS_SVH
`define I2CST_ST_OWN_READ    8'ha8
`define I2CST_ST_ARB_READ    8'hb0
`define I2CST_ST_DATA_ACK    8'hb8
`define I2CST_ST_DATA_NACK   8'hc0
`define I2CST_ST_LAST_ACK    8'hc8
`define I2CST_ST_NO_INFO     8'hf8
`define I2CST_GC_ADDRESS     7'h00
`define I2CST_ADR_GC_BIT     0
`define I2CST_BITS_PER_BYTE  4'h8
`endif

// >>> hw/i2cst_pkg.sv
/*
 * Types of the I2C slave transmitter.
 * Assumes the params header sits beside it.
 */
package i2cst_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WAIT_SW,
        ST_SEND,
        ST_GET_ACK,
        ST_IGNORE
    } i2cst_state_e;

    typedef struct packed {
        logic start_request;
        logic acknowledge_enable;
        logic arb_lost;
    } i2cst_ctrl_s;
endpackage

// >>> hw/i2cst_slave_tx.sv
/*
 * Slave transmitter of an I2C controller with status codes and a serial
 * interrupt flag. Assumes open-drain bus pins resolved outside, and a
 * software side on the same clock that loads bytes and clears the flag.
 */
`timescale 1ns/100ps
`include "i2cst_params.svh"
`default_nettype none
module i2cst_slave_tx (
    // Clock and reset.
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    // Bus pins.
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    // Software side.
    input  wire logic [7:0]         own_slave_address,
    input  wire i2cst_pkg::i2cst_ctrl_s control_register,
    input  wire logic [7:0]         tx_byte,
    input  wire logic               tx_load,
    input  wire logic               flag_clear,
    output logic                    serial_flag,
    output logic [7:0]              status_code,
    output logic                    start_pending
);
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    i2cst_pkg::i2cst_state_e state_reg;
    logic [7:0] data_shift_register;
    logic [3:0] bit_cnt_reg;
    logic       last_reg;
    logic       addressed_read;
    logic       recog_reg;

    assign scl_s      = scl_sync_reg[1];
    assign sda_s      = sda_sync_reg[1];
    assign scl_rise   = scl_s && !scl_d_reg;
    assign scl_fall   = !scl_s && scl_d_reg;
    assign start_seen = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_seen  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    // Address match on the received byte, direction bit excluded.
    function automatic logic addr_hit(input logic [7:0] rx,
                                      input logic [7:0] adr);
        addr_hit = (rx[7:1] == adr[7:1]) ||
                   ((rx[7:1] == `I2CST_GC_ADDRESS) &&
                    adr[`I2CST_ADR_GC_BIT]);
    endfunction

    assign addressed_read = recog_reg && data_shift_register[0] &&
        addr_hit(data_shift_register, own_slave_address);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_d_reg    <= scl_s;
            sda_d_reg    <= sda_s;
        end
    end

    // Address recognition follows acknowledge enable at any time.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            recog_reg <= 1'b0;
        end else begin
            recog_reg <= control_register.acknowledge_enable;
        end
    end

    // Start request latched when the flag clears in a terminating state.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_pending <= 1'b0;
        end else if (flag_clear && serial_flag &&
                     control_register.start_request &&
                     (status_code == `I2CST_ST_DATA_NACK ||
                      status_code == `I2CST_ST_LAST_ACK)) begin
            start_pending <= 1'b1;
        end else if (stop_seen) begin
            start_pending <= 1'b0;
        end
    end

    // Main sequencer, bit shifter, flag and status.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg           <= i2cst_pkg::ST_IDLE;
            data_shift_register <= 8'h00;
            bit_cnt_reg         <= 4'h0;
            last_reg            <= 1'b0;
            sda_out             <= 1'b0;
            sda_oe              <= 1'b0;
            serial_flag         <= 1'b0;
            status_code         <= `I2CST_ST_NO_INFO;
        end else begin
            if (flag_clear && serial_flag) begin
                serial_flag <= 1'b0;
                status_code <= `I2CST_ST_NO_INFO;
            end
            if (start_seen) begin
                state_reg   <= i2cst_pkg::ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe      <= 1'b0;
            end else if (stop_seen) begin
                state_reg <= i2cst_pkg::ST_IDLE;
                sda_oe    <= 1'b0;
            end else begin
                unique case (state_reg)
                    i2cst_pkg::ST_IDLE, i2cst_pkg::ST_IGNORE: begin
                        sda_oe <= 1'b0;
                    end
                    i2cst_pkg::ST_ADDR: begin
                        if (scl_rise) begin
                            data_shift_register <=
                                {data_shift_register[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall &&
                                     bit_cnt_reg == `I2CST_BITS_PER_BYTE) begin
                            if (addressed_read) begin
                                sda_out   <= 1'b0;
                                sda_oe    <= 1'b1;
                                state_reg <= i2cst_pkg::ST_ADDR_ACK;
                            end else begin
                                state_reg <= i2cst_pkg::ST_IGNORE;
                            end
                        end
                    end
                    i2cst_pkg::ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            sda_oe      <= 1'b0;
                            serial_flag <= 1'b1;
                            status_code <= control_register.arb_lost ?
                                `I2CST_ST_ARB_READ :
                                `I2CST_ST_OWN_READ;
                            state_reg   <= i2cst_pkg::ST_WAIT_SW;
                        end
                    end
                    i2cst_pkg::ST_WAIT_SW: begin
                        if (tx_load) begin
                            data_shift_register <= tx_byte;
                        end
                        if (flag_clear && serial_flag) begin
                            last_reg <= !control_register.acknowledge_enable;
                            bit_cnt_reg <= 4'h0;
                            sda_out     <= tx_load ? tx_byte[7] :
                                           data_shift_register[7];
                            sda_oe      <= 1'b1;
                            state_reg   <= i2cst_pkg::ST_SEND;
                        end
                    end
                    i2cst_pkg::ST_SEND: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_reg == `I2CST_BITS_PER_BYTE) begin
                                sda_oe    <= 1'b0;
                                state_reg <= i2cst_pkg::ST_GET_ACK;
                            end else begin
                                data_shift_register <=
                                    {data_shift_register[6:0], 1'b1};
                                sda_out <= data_shift_register[6];
                            end
                        end
                    end
                    i2cst_pkg::ST_GET_ACK: begin
                        if (scl_rise) begin
                            serial_flag <= 1'b1;
                            if (sda_s) begin
                                status_code <= `I2CST_ST_DATA_NACK;
                                state_reg   <= i2cst_pkg::ST_IGNORE;
                            end else if (last_reg) begin
                                status_code <= `I2CST_ST_LAST_ACK;
                                state_reg   <= i2cst_pkg::ST_IGNORE;
                            end else begin
                                status_code <= `I2CST_ST_DATA_ACK;
                                state_reg   <= i2cst_pkg::ST_WAIT_SW;
                            end
                        end
                    end
                    default: begin
                        state_reg <= i2cst_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Checks of status codes, flag, data line release and start request.
    flag_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !serial_flag |-> status_code == `I2CST_ST_NO_INFO)
        else $error("status not 0xf8 with flag clear");
    ignore_release_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        state_reg == i2cst_pkg::ST_IGNORE |=> !sda_oe)
        else $error("data line held while not addressed");
    addr_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == i2cst_pkg::ST_ADDR_ACK && scl_fall && !start_seen
         && !stop_seen) |=> serial_flag &&
        (status_code == `I2CST_ST_OWN_READ ||
         status_code == `I2CST_ST_ARB_READ))
        else $error("flag not set after own read address");
    read_only_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(state_reg == i2cst_pkg::ST_ADDR_ACK) |->
        $past(data_shift_register[0]) && $past(recog_reg))
        else $error("entered transmit without read bit");
    arb_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == i2cst_pkg::ST_ADDR_ACK && scl_fall && !start_seen &&
         !stop_seen && control_register.arb_lost) |=>
        status_code == `I2CST_ST_ARB_READ)
        else $error("arbitration status missing");
    nack_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == i2cst_pkg::ST_GET_ACK && scl_rise && sda_s &&
         !start_seen && !stop_seen) |=>
        status_code == `I2CST_ST_DATA_NACK &&
        state_reg == i2cst_pkg::ST_IGNORE)
        else $error("nack not reported");
    last_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == i2cst_pkg::ST_GET_ACK && scl_rise && !sda_s &&
         last_reg && !start_seen && !stop_seen) |=>
        status_code == `I2CST_ST_LAST_ACK)
        else $error("last byte ack not reported");
    more_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == i2cst_pkg::ST_GET_ACK && scl_rise && !sda_s &&
         !last_reg && !start_seen && !stop_seen) |=>
        status_code == `I2CST_ST_DATA_ACK)
        else $error("byte ack not reported");
    stable_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == i2cst_pkg::ST_SEND && scl_s && scl_d_reg &&
         $past(scl_s)) |-> $stable(sda_out))
        else $error("data changed while clock high");
    no_recog_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (state_reg == i2cst_pkg::ST_ADDR && scl_fall && !recog_reg &&
         bit_cnt_reg == `I2CST_BITS_PER_BYTE && !start_seen &&
         !stop_seen) |=> state_reg == i2cst_pkg::ST_IGNORE && !sda_oe)
        else $error("address recognised while disabled");
    last_pick_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (state_reg == i2cst_pkg::ST_WAIT_SW && flag_clear && serial_flag &&
         !start_seen && !stop_seen) |=> state_reg == i2cst_pkg::ST_SEND &&
        sda_oe && last_reg == !$past(control_register.acknowledge_enable))
        else $error("last byte choice not taken at flag clear");
    msb_first_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (state_reg == i2cst_pkg::ST_WAIT_SW && flag_clear && serial_flag &&
         tx_load && !start_seen && !stop_seen) |=>
        sda_out == $past(tx_byte[7]))
        else $error("first bit is not the top bit of the byte");
    ack_release_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (state_reg == i2cst_pkg::ST_SEND && scl_fall && !start_seen &&
         !stop_seen && bit_cnt_reg == `I2CST_BITS_PER_BYTE) |=>
        !sda_oe && state_reg == i2cst_pkg::ST_GET_ACK)
        else $error("data line not released for the ninth clock");
    start_set_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (flag_clear && serial_flag && control_register.start_request &&
         (status_code == `I2CST_ST_DATA_NACK ||
          status_code == `I2CST_ST_LAST_ACK)) |=> start_pending)
        else $error("start request not kept at flag clear");
    start_drop_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (stop_seen && !flag_clear) |=> !start_pending)
        else $error("start request kept after the bus became free");

    addr_read_c: cover property (@(posedge core_clk)
        status_code == `I2CST_ST_OWN_READ);
    data_ack_c: cover property (@(posedge core_clk)
        status_code == `I2CST_ST_DATA_ACK);
    last_ack_c: cover property (@(posedge core_clk)
        status_code == `I2CST_ST_LAST_ACK);
    nack_c: cover property (@(posedge core_clk)
        status_code == `I2CST_ST_DATA_NACK);
    arb_read_c: cover property (@(posedge core_clk)
        status_code == `I2CST_ST_ARB_READ);
endmodule
`default_nettype wire

// >>> sim/i2cst_master_model.sv
/*
 * Bus master receiver model that clocks the slave transmitter.
 * Assumes a pull-up on the data line and the bench clock as its time base.
 */
`timescale 1ns/100ps
`default_nettype none
module i2cst_master_model (
    // Time base.
    input  wire logic clk,
    // Device data pin.
    input  wire logic sda_out,
    input  wire logic sda_oe,
    // Resolved bus lines.
    output var logic  scl,
    output wire logic sda
);
    logic m_low;

    // Wired-AND with a pull-up, so released lines read as one.
    assign sda = ~(m_low | (sda_oe & ~sda_out));

    initial begin
        scl = 1'b1;
        m_low = 1'b0;
    end

    task automatic q(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic start_c();
        m_low <= 1'b1;
        q(4);
        scl <= 1'b0;
        q(2);
    endtask

    task automatic stop_c();
        m_low <= 1'b1;
        q(2);
        scl <= 1'b1;
        q(2);
        m_low <= 1'b0;
        q(4);
    endtask

    // One bit: data moves only while the clock is low, 400 ns per bit.
    task automatic clk_bit(input logic drive_low, output logic seen);
        m_low <= drive_low;
        q(2);
        scl <= 1'b1;
        q(3);
        seen = sda;
        q(1);
        scl <= 1'b0;
        q(2);
    endtask

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(~b[i], s);
        end
        clk_bit(1'b0, ack);
    endtask

    // Reads a byte and answers with acknowledge or not.
    task automatic read_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b0, s);
            b[i] = s;
        end
        clk_bit(~nack, s);
    endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
/*
 * Testbench of the slave transmitter: software calls and master reads.
 * Assumes the design, its package and the master model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic                   core_clk;
    logic                   sys_rst;
    logic                   scl;
    wire logic              sda;
    logic                   sda_out;
    logic                   sda_oe;
    logic [7:0]             own_slave_address;
    i2cst_pkg::i2cst_ctrl_s control_register;
    logic [7:0]             tx_byte;
    logic                   tx_load;
    logic                   flag_clear;
    logic                   serial_flag;
    logic [7:0]             status_code;
    logic                   start_pending;
    logic                   a;
    logic [7:0]             d;
    int                     n_mismatch;
    int                     num_checks;

    i2cst_slave_tx dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .own_slave_address(own_slave_address),
        .control_register(control_register), .tx_byte(tx_byte),
        .tx_load(tx_load), .flag_clear(flag_clear),
        .serial_flag(serial_flag), .status_code(status_code),
        .start_pending(start_pending));

    i2cst_master_model master (.clk(core_clk), .sda_out(sda_out),
        .sda_oe(sda_oe), .scl(scl), .sda(sda));

    always #25 core_clk = ~core_clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic wait_flag();
        for (int i = 0; i < 200 && serial_flag !== 1'b1; i++) begin
            @(posedge core_clk);
        end
        if (serial_flag !== 1'b1) begin
            $display("ERROR at %0t: flag got %h expected %h", $time,
                     serial_flag, 1'b1);
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    // Software answer: optional load, flag clear, control bits chosen.
    task automatic sw(input logic [7:0] b, input logic ae, input logic st,
                      input logic load);
        @(posedge core_clk);
        control_register <= '{st, ae, control_register.arb_lost};
        tx_byte <= b;
        tx_load <= load;
        flag_clear <= 1'b1;
        @(posedge core_clk);
        tx_load <= 1'b0;
        flag_clear <= 1'b0;
        @(posedge core_clk);
    endtask

    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        own_slave_address = 8'h54;
        control_register = '{1'b0, 1'b1, 1'b0};
        tx_byte = 8'h00;
        tx_load = 1'b0;
        flag_clear = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(status_code, 8'hf8);
        master.start_c();
        master.write_byte(8'h54, a);
        chk({7'h00, a}, 8'h01);
        master.stop_c();
        master.start_c();
        master.write_byte(8'h01, a);
        chk({7'h00, a}, 8'h01);
        master.stop_c();
        master.start_c();
        master.write_byte(8'h55, a);
        chk({7'h00, a}, 8'h00);
        wait_flag();
        chk(status_code, 8'ha8);
        sw(8'ha5, 1'b1, 1'b0, 1'b1);
        chk(status_code, 8'hf8);
        master.read_byte(1'b0, d);
        chk(d, 8'ha5);
        wait_flag();
        chk(status_code, 8'hb8);
        sw(8'h3c, 1'b0, 1'b0, 1'b1);
        master.read_byte(1'b0, d);
        chk(d, 8'h3c);
        wait_flag();
        chk(status_code, 8'hc8);
        sw(8'h00, 1'b1, 1'b1, 1'b0);
        chk({7'h00, start_pending}, 8'h01);
        master.read_byte(1'b1, d);
        chk(d, 8'hff);
        master.stop_c();
        chk({7'h00, start_pending}, 8'h00);
        control_register.arb_lost <= 1'b1;
        master.start_c();
        master.write_byte(8'h55, a);
        wait_flag();
        chk(status_code, 8'hb0);
        sw(8'hc3, 1'b1, 1'b0, 1'b1);
        master.read_byte(1'b1, d);
        chk(d, 8'hc3);
        wait_flag();
        chk(status_code, 8'hc0);
        sw(8'h00, 1'b0, 1'b0, 1'b0);
        master.stop_c();
        control_register.arb_lost <= 1'b0;
        master.start_c();
        master.write_byte(8'h55, a);
        chk({7'h00, a}, 8'h01);
        chk({7'h00, serial_flag}, 8'h00);
        master.stop_c();
        control_register.acknowledge_enable <= 1'b1;
        master.start_c();
        master.write_byte(8'h55, a);
        chk({7'h00, a}, 8'h00);
        wait_flag();
        chk(status_code, 8'ha8);
        sw(8'h00, 1'b0, 1'b0, 1'b1);
        master.read_byte(1'b1, d);
        chk(d, 8'h00);
        wait_flag();
        chk(status_code, 8'hc0);
        sw(8'h00, 1'b1, 1'b0, 1'b0);
        master.stop_c();
        own_slave_address <= 8'h55;
        master.start_c();
        master.write_byte(8'h01, a);
        chk({7'h00, a}, 8'h00);
        wait_flag();
        chk(status_code, 8'ha8);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk({6'h00, serial_flag, sda_oe}, 8'h00);
        chk(status_code, 8'hf8);
        master.stop_c();
        tally_and_finish();
    end
endmodule
`default_nettype wire
